// ==== branch_call_skip_irq_ops.sv ====
// Control-flow, skip, interrupt and control-register instruction core.
//
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`include "bcs_defines.svh"
module branch_call_skip_irq_ops
	import bcs_pkg::*;
#(
	parameter bit LARGE_VARIANT = 1'b1
) (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Program memory
	output logic [13:0]      fetch_addr,
	input  wire logic [9:0]  fetch_word,
	input  wire logic        fetch_valid,
	// Data memory and pins
	input  wire logic [3:0]  mem_nibble,
	input  wire logic        ext_int_pin,
	input  wire logic        ext0_event,
	input  wire logic        irq_req,
	// AXI4-Lite slave
	input  wire logic [31:0] s_awaddr,
	input  wire logic        s_awvalid,
	output logic             s_awready,
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0]  s_wstrb,
	input  wire logic        s_wvalid,
	output logic             s_wready,
	output logic [1:0]       s_bresp,
	output logic             s_bvalid,
	input  wire logic        s_bready,
	input  wire logic [31:0] s_araddr,
	input  wire logic        s_arvalid,
	output logic             s_arready,
	output logic [31:0]      s_rdata,
	output logic [1:0]       s_rresp,
	output logic             s_rvalid,
	input  wire logic        s_rready
);
	// ****************************************
	// Core state
	// ****************************************
	state_t      st_q;
	logic [13:0] pc_q;
	logic [2:0]  sp_q;
	logic [13:0] stack_q [8];
	ctx_t        ctx_q;
	ctx_t        saved_q;
	logic [9:0]  first_q;
	logic        inte_q;
	logic        ext0_q;
	logic        pa_q;
	logic [3:0]  ctl_q [8];
	logic        run_q;

	// ****************************************
	// Decode
	// ****************************************
	wire go      = run_q & fetch_valid;
	wire irq_tk  = go & (st_q == ST_ONE) & inte_q & irq_req;
	wire ex1     = go & (st_q == ST_ONE) & ~irq_tk & ~ctx_q.skip;
	wire sk1     = go & (st_q == ST_ONE) & ~irq_tk & ctx_q.skip;
	wire ex2     = go & (st_q == ST_TWO);
	wire [9:0] w = fetch_word;
	wire is_fj   = (w & `M_FAR) == `OP_FAR_JMP;
	wire is_fc   = (w & `M_FAR) == `OP_FAR_CALL;
	wire is_nj   = (w & `M_NEAR) == `OP_NEAR_JMP;
	wire is_pc2  = (w & `M_NEAR) == `OP_PG2_CALL;
	wire two_w   = is_fj | is_fc | (w == `OP_IND_JMP) |
		(w == `OP_IND_CALL) | (w == `OP_SEA);
	wire is_call = is_pc2 | (ex2 & (((first_q & `M_FAR) == `OP_FAR_CALL) |
		(first_q == `OP_IND_CALL)));
	wire is_ret  = (w == `OP_RT) | (w == `OP_RTS) | (w == `OP_RTI);
	wire [13:0] pc_inc = {pc_q[13:7], pc_q[6:0] + 7'h01};
	wire [2:0]  sp_inc = sp_q + 3'h1;
	// The top page bit (bit 6) is forced low on the small variant.
	wire [6:0] pg_dir = {LARGE_VARIANT & w[8], w[7], first_q[4:0]};
	wire [6:0] pg_ind = {LARGE_VARIANT & w[8], w[7:6], w[3:0]};
	wire [6:0] a_ind  = {ctx_q.d, ctx_q.acc};
	wire indirect = (first_q == `OP_IND_JMP) | (first_q == `OP_IND_CALL);
	wire [13:0] tgt2 = indirect ? {pg_ind, a_ind} : {pg_dir, w[6:0]};
	wire ext0_en = ctl_q[`V1_IDX][`EXT0_EN_BIT];
	wire pin_pol = ctl_q[`I1_IDX][`PIN_POL_BIT];
	wire test_ext0_request_op_hit = ext0_q & ~ext0_en;
	wire test_ext0_request_op_clr = ex1 & (w == `OP_TEST_EXT0_REQUEST_OP) & test_ext0_request_op_hit;
	wire pin_hit  = ext_int_pin == pin_pol;
	// Control register transfers: index 0..7 selects V1,V2,I1,W1..W5.
	wire to_a = (w == 10'h054) | (w == 10'h055) | (w == 10'h253) |
		((w >= 10'h24B) & (w <= 10'h24F));
	wire from_a = (w == 10'h03F) | (w == 10'h03E) | (w == 10'h217) |
		(w == 10'h20E) | (w == 10'h20F) |
		((w >= 10'h210) & (w <= 10'h212));
	wire [2:0] to_idx = (w == 10'h054) ? 3'h0 : (w == 10'h055) ? 3'h1 :
		(w == 10'h253) ? 3'h2 : 3'(w[2:0] - 3'h0);
	wire [2:0] from_idx = (w == 10'h03F) ? 3'h0 :
		(w == 10'h03E) ? 3'h1 : (w == 10'h217) ? 3'h2 :
		(w[4] ? 3'(w[2:0] + 3'h5) : 3'(w[2:0] - 3'h3));

	wire wr_core;
	wire wr_ctrl;
	wire [31:0] wmask;
	wire [31:0] core_rd;

	assign fetch_addr = pc_q;

	// ****************************************
	// Sequencer
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q    <= ST_ONE;
			pc_q    <= `RST_PC;
			sp_q    <= 3'h0;
			ctx_q   <= '0;
			saved_q <= '0;
			first_q <= 10'h000;
			inte_q  <= 1'b0;
			ext0_q  <= 1'b0;
			pa_q    <= 1'b0;
			for (int i = 0; i < 8; i++) begin
				ctl_q[i]   <= `RST_NIB;
				stack_q[i] <= `RST_PC;
			end
		end else begin
			// A new request wins over the clear in the same cycle.
			if (ext0_event) begin
				ext0_q <= 1'b1;
			end else if (test_ext0_request_op_clr && !wr_core) begin
				ext0_q <= 1'b0;
			end
			if (wr_core) begin
				ctx_q <= (ctx_q & ~wmask[21:0]) | (wdata_q[21:0] & wmask[21:0]);
			end else if (irq_tk) begin
				stack_q[sp_inc] <= pc_q;
				sp_q    <= sp_inc;
				saved_q <= ctx_q;
				ctx_q.skip <= 1'b0;
				inte_q  <= 1'b0;
				pc_q    <= `IRQ_VEC;
			end else if (sk1) begin
				ctx_q.skip <= 1'b0;
				pc_q <= pc_inc;
				if (two_w) begin
					st_q <= ST_SKIP2;
				end
			end else if (go && st_q == ST_SKIP2) begin
				pc_q <= pc_inc;
				st_q <= ST_ONE;
			end else if (ex2) begin
				st_q <= ST_ONE;
				if (first_q == `OP_SEA) begin
					ctx_q.skip <= ctx_q.acc == w[3:0];
					pc_q <= pc_inc;
				end else begin
					pc_q <= tgt2;
					if (is_call) begin
						stack_q[sp_inc] <= pc_inc;
						sp_q <= sp_inc;
					end
				end
			end else if (ex1) begin
				pc_q <= pc_inc;
				if (two_w) begin
					first_q <= w;
					st_q    <= ST_TWO;
				end else if (is_nj) begin
					pc_q <= {pc_q[13:7], w[6:0]};
				end else if (is_pc2) begin
					pc_q <= {`PAGE_CALL, w[6:0]};
					stack_q[sp_inc] <= pc_inc;
					sp_q <= sp_inc;
				end else if (is_ret) begin
					pc_q <= stack_q[sp_q];
					sp_q <= sp_q - 3'h1;
					if (w == `OP_RTS) begin
						ctx_q.skip <= 1'b1;
					end
					if (w == `OP_RTI) begin
						ctx_q <= saved_q;
					end
				end else if (w == `OP_CMPM) begin
					ctx_q.skip <= ctx_q.acc == mem_nibble;
				end else if (w == `OP_TEST_EXT0_REQUEST_OP) begin
					ctx_q.skip <= test_ext0_request_op_hit;
				end else if (w == `OP_TEST_EXT_PIN_LEVEL_OP) begin
					ctx_q.skip <= pin_hit;
				end else if (w == `OP_DI || w == `OP_EI) begin
					inte_q <= w[0];
				end else if (w == `OP_TPAA) begin
					pa_q <= ctx_q.acc[0];
				end else if (to_a) begin
					ctx_q.acc <= ctl_q[to_idx];
				end else if (from_a) begin
					ctl_q[from_idx] <= ctx_q.acc;
				end
			end
		end
	end

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	logic        aw_got_q;
	logic        w_got_q;
	logic [31:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	wire do_wr   = aw_got_q & w_got_q & ~s_bvalid;
	wire wr_map  = awaddr_q[31:4] == 28'h0;
	assign wr_ctrl = do_wr & wr_map & (awaddr_q[3:0] == `REG_CTRL);
	// Core context is loaded in any cycle, ahead of the sequencer, even between the two words of a pair.
	assign wr_core = do_wr & wr_map & (awaddr_q[3:0] == `REG_CORE);
	assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
		{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	assign s_awready = ~aw_got_q;
	assign s_wready  = ~w_got_q;
	assign s_arready = ~s_rvalid;
	wire rd_map = s_araddr[31:4] == 28'h0;
	assign core_rd = {10'h000, 22'(ctx_q)};
	wire [31:0] status_rd = {11'h000, pa_q, ext0_q, ctx_q.skip, inte_q,
		sp_q, pc_q};
	wire [31:0] ctl_rd = {ctl_q[7], ctl_q[6], ctl_q[5], ctl_q[4],
		ctl_q[3], ctl_q[2], ctl_q[1], ctl_q[0]};
	wire [31:0] rd_mux = (s_araddr[3:0] == `REG_CTRL) ? {31'h0, run_q} :
		(s_araddr[3:0] == `REG_STATUS) ? status_rd :
		(s_araddr[3:0] == `REG_CORE) ? core_rd :
		(s_araddr[3:0] == `REG_CTL) ? ctl_rd : 32'h0;
	wire rd_ok = rd_map & (s_araddr[1:0] == 2'h0);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q <= 1'b0;
			w_got_q  <= 1'b0;
			awaddr_q <= 32'h0;
			wdata_q  <= 32'h0;
			wstrb_q  <= 4'h0;
			s_bvalid <= 1'b0;
			s_bresp  <= `RESP_OKAY;
			run_q    <= 1'b0;
		end else begin
			if (s_awvalid && !aw_got_q) begin
				aw_got_q <= 1'b1;
				awaddr_q <= s_awaddr;
			end
			if (s_wvalid && !w_got_q) begin
				w_got_q <= 1'b1;
				wdata_q <= s_wdata;
				wstrb_q <= s_wstrb;
			end
			if (do_wr) begin
				s_bvalid <= 1'b1;
				s_bresp  <= (wr_map && awaddr_q[1:0] == 2'h0) ?
					`RESP_OKAY : `RESP_DECERR;
				if (wr_ctrl && wstrb_q[0]) begin
					run_q <= wdata_q[0];
				end
			end else if (s_bvalid && s_bready) begin
				s_bvalid <= 1'b0;
				aw_got_q <= 1'b0;
				w_got_q  <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_rvalid <= 1'b0;
			s_rdata  <= 32'h0;
			s_rresp  <= `RESP_OKAY;
		end else if (s_arvalid && !s_rvalid) begin
			s_rvalid <= 1'b1;
			s_rdata  <= rd_ok ? rd_mux : 32'h0;
			s_rresp  <= rd_ok ? `RESP_OKAY : `RESP_DECERR;
		end else if (s_rready) begin
			s_rvalid <= 1'b0;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire nw = ~wr_core;

	cmp_mem_skip_a: assert property (
		ex1 && nw && w == `OP_CMPM |=>
			ctx_q.skip == ($past(ctx_q.acc) == $past(mem_nibble)))
		else $error("compare with memory skip wrong");
	cmp_imm_skip_a: assert property (
		ex2 && nw && first_q == `OP_SEA |=>
			ctx_q.skip == ($past(ctx_q.acc) == $past(w[3:0])))
		else $error("compare immediate skip wrong");
	near_jump_a: assert property (
		ex1 && nw && is_nj |=>
			pc_q == {$past(pc_q[13:7]), $past(w[6:0])})
		else $error("near jump target wrong");
	page2_call_a: assert property (
		ex1 && nw && is_pc2 |=> pc_q[13:7] == `PAGE_CALL &&
			sp_q == $past(sp_inc) && stack_q[sp_q] == $past(pc_inc))
		else $error("page two call wrong");
	ret_pop_a: assert property (
		ex1 && nw && w == `OP_RT |=>
			pc_q == $past(stack_q[sp_q]) && sp_q == $past(sp_q) - 3'h1)
		else $error("return pop wrong");
	rts_skip_a: assert property (
		ex1 && nw && w == `OP_RTS ##1 go && nw && !irq_tk |=>
			pc_q == {$past(pc_q[13:7]), $past(pc_q[6:0]) + 7'h01})
		else $error("return and skip did not skip");
	test_ext0_request_op_nop_a: assert property (
		ex1 && nw && w == `OP_TEST_EXT0_REQUEST_OP && ext0_en && !ext0_event |=>
			!ctx_q.skip && ext0_q == $past(ext0_q))
		else $error("request test not a no-operation");
	pin_test_a: assert property (
		ex1 && nw && w == `OP_TEST_EXT_PIN_LEVEL_OP |=>
			ctx_q.skip == ($past(ext_int_pin) == $past(pin_pol)))
		else $error("pin level test wrong");
	irq_flag_a: assert property (
		ex1 && nw && (w == `OP_DI || w == `OP_EI) |=>
			inte_q == $past(w[0]))
		else $error("global enable not updated");
	rti_restore_a: assert property (
		ex1 && nw && w == `OP_RTI |=> ctx_q == $past(saved_q))
		else $error("interrupt return context wrong");

	far_call_c: cover property (ex2 && is_call);
	irq_ret_c: cover property (irq_tk ##[1:20] ex1 && w == `OP_RTI);
	skip_two_c: cover property (sk1 && two_w ##1 st_q == ST_SKIP2);
endmodule

// ==== bcs_defines.svh ====
// Opcodes, register offsets, field positions and reset values of the core.
`ifndef BCS_DEFINES_SVH
`define BCS_DEFINES_SVH
// ****************************************
// Instruction words
// ****************************************
`define OP_DI        10'h004
`define OP_EI        10'h005
`define OP_IND_JMP   10'h010
`define OP_SEA       10'h025
`define OP_CMPM      10'h026
`define OP_IND_CALL  10'h030
`define OP_TEST_EXT0_REQUEST_OP      10'h038
`define OP_TEST_EXT_PIN_LEVEL_OP     10'h03A
`define OP_RT        10'h044
`define OP_RTS       10'h045
`define OP_RTI       10'h046
`define OP_TPAA      10'h2AA
`define M_FAR        10'h3E0
`define OP_FAR_JMP   10'h0E0
`define OP_FAR_CALL  10'h0C0
`define M_NEAR       10'h380
`define OP_NEAR_JMP  10'h180
`define OP_PG2_CALL  10'h100
`define PAGE_CALL    7'h02
`define IRQ_VEC      14'h0002
// ****************************************
// Control register fields
// ****************************************
`define V1_IDX       3'h0
`define I1_IDX       3'h2
`define EXT0_EN_BIT  0
`define PIN_POL_BIT  2
// ****************************************
// Bus register map and reset values
// ****************************************
`define REG_CTRL     4'h0
`define REG_STATUS   4'h4
`define REG_CORE     4'h8
`define REG_CTL      4'hC
`define RESP_OKAY    2'h0
`define RESP_DECERR  2'h3
`define RST_PC       14'h0000
`define RST_NIB      4'h0
`endif

// ==== bcs_pkg.sv ====
// Types shared by the control-flow core.
package bcs_pkg;
	typedef struct packed {
		logic       nop_mode;
		logic       skip;
		logic       carry;
		logic [7:0] dp;
		logic [2:0] d;
		logic [3:0] b;
		logic [3:0] acc;
	} ctx_t;
	typedef enum logic [2:0] {
		ST_ONE   = 3'b001,
		ST_TWO   = 3'b010,
		ST_SKIP2 = 3'b100
	} state_t;
endpackage

// ==== prog_mem_model.sv ====
// Program memory model that feeds 10-bit words to the core.
`timescale 1ns/1ps
module prog_mem_model (
	// Clock
	input  wire logic        aclk,
	// Fetch port
	input  wire logic [13:0] fetch_addr,
	output logic [9:0]       fetch_word,
	output logic             fetch_valid,
	// Pacing from the bench
	input  wire logic        en,
	input  wire logic        slow
);
	logic [9:0] mem [0:16383];
	logic       tick_q = 1'b0;
	// ****
	// Fetch
	// ****
	// Slow mode offers a word only every other cycle.
	assign fetch_valid = en & (~slow | tick_q);
	// Outside a valid cycle the word is 10'h155 or 10'h2AA by tick, so a stale word never passes.
	assign fetch_word = fetch_valid ? mem[fetch_addr]
		: (tick_q ? 10'h2AA : 10'h155);
	always @(posedge aclk) begin
		tick_q <= ~tick_q;
	end
endmodule

// ==== testbench.sv ====
// Self-checking bench for the control-flow core.
`timescale 1ns/1ps
`include "bcs_defines.svh"
module testbench;
	import bcs_pkg::*;
	logic        aclk, aresetn, fetch_valid, en, slow;
	logic        ext_int_pin, ext0_event, irq_req;
	logic [13:0] fetch_addr, cur;
	logic [9:0]  fetch_word;
	logic [3:0]  mem_nibble;
	logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid;
	logic        s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
	logic [31:0] s_awaddr, s_wdata, s_araddr, s_rdata, d, core0;
	logic [1:0]  s_bresp, s_rresp, r;
	int          bad_count, n_checks;
	branch_call_skip_irq_ops branch_call_skip_irq_ops_i (.aclk, .aresetn,
		.fetch_addr, .fetch_word, .fetch_valid, .mem_nibble, .ext_int_pin,
		.ext0_event, .irq_req, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
		.s_wstrb(4'hF), .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
		.s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
		.s_rready);
	prog_mem_model prog_mem_model_i (.aclk, .fetch_addr, .fetch_word,
		.fetch_valid, .en, .slow);
	// ****
	// Tasks
	// ****
	task close_out();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task ck(input logic [31:0] g, e);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %0t got %h exp %h", $time, g, e);
		end
	endtask
	task wr(input logic [31:0] a, v);
		s_awaddr <= a;
		s_wdata <= v;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_awready) s_awvalid <= 1'b0;
			if (s_wready) s_wvalid <= 1'b0;
		end while (!s_bvalid);
		r = s_bresp;
		s_bready <= 1'b0;
	endtask
	task rd(input logic [31:0] a);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_arready) s_arvalid <= 1'b0;
		end while (!s_rvalid);
		d = s_rdata;
		r = s_rresp;
		s_rready <= 1'b0;
	endtask
	function automatic logic [9:0] nj(input logic [13:0] a);
		return `OP_NEAR_JMP | {3'h0, a[6:0]};
	endfunction
	task put(input logic [13:0] a, input logic [9:0] w);
		prog_mem_model_i.mem[a] = w;
	endtask
	// Every program ends in a self-loop, so extra cycles cannot move the pc.
	task go();
		en <= 1'b1;
		repeat (12) @(posedge aclk);
		en <= 1'b0;
		@(posedge aclk);
	endtask
	task pc_is(input logic [13:0] e);
		rd(32'(`REG_STATUS));
		ck(32'(d[13:0]), 32'(e));
		cur = e;
	endtask
	task one(input logic [9:0] w);
		put(cur, w);
		put(cur + 14'd1, nj(cur + 14'd1));
		go();
		pc_is(cur + 14'd1);
	endtask
	task seta(input logic [3:0] a);
		wr(32'(`REG_CORE), {core0[31:4], a});
	endtask
	task jmp(input logic [9:0] w0, w1, input logic [13:0] t);
		put(cur, w0);
		put(cur + 14'd1, w1);
		put(t, nj(t));
		go();
		pc_is(t);
	endtask
	task sk(input logic [9:0] w0, w1, input bit two, hit);
		logic [13:0] b;
		b = cur;
		put(b, w0);
		if (two) put(b + 14'd1, w1);
		put(b + 14'd1 + 14'(two), nj(b + 14'd4));
		put(b + 14'd2 + 14'(two), nj(b + 14'd2 + 14'(two)));
		put(b + 14'd4, nj(b + 14'd4));
		go();
		pc_is(hit ? b + 14'd2 + 14'(two) : b + 14'd4);
	endtask
	task cr(input logic [9:0] w0, w1, input bit two,
		input logic [13:0] t, input logic [9:0] rop, input bit rs);
		logic [13:0] b;
		b = cur;
		put(b, w0);
		if (two) put(b + 14'd1, w1);
		put(t, nj(t));
		go();
		pc_is(t);
		ck(32'(d[16:14]), 32'd1);
		put(t, rop);
		put(b + 14'd1 + 14'(two), nj(b + 14'd5));
		put(b + 14'd2 + 14'(two), nj(b + 14'd2 + 14'(two)));
		put(b + 14'd5, nj(b + 14'd5));
		go();
		pc_is(rs ? b + 14'd2 + 14'(two) : b + 14'd5);
		ck(32'(d[16:14]), 32'd0);
	endtask
	// ****
	// Stimulus
	// ****
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	initial begin
		repeat (20000) @(posedge aclk);
		bad_count++;
		close_out();
	end
	initial begin
		{aresetn, en, slow, ext_int_pin, ext0_event, irq_req} = 6'h00;
		{s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
		{s_awaddr, s_wdata, s_araddr} = 96'h0;
		mem_nibble = 4'h5;
		bad_count = 0;
		n_checks = 0;
		cur = 14'h0000;
		core0 = {10'h000, 3'h1, 8'h5A, 3'h3, 4'hA, 4'h5};
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		wr(32'(`REG_CORE), core0);
		ck(32'(r), 32'(`RESP_OKAY));
		wr(32'(`REG_CTRL), 32'h0000_0001);
		rd(32'(`REG_CORE));
		ck(d, core0);
		rd(32'h0000_0010);
		ck(32'({d, r}), 32'(`RESP_DECERR));
		jmp(`OP_FAR_JMP | 10'h005, {3'b101, 7'h11}, {7'h25, 7'h11});
		jmp(`OP_IND_JMP, {4'b1001, 2'b00, 4'h2}, {7'h12, 7'h35});
		slow <= 1'b1;
		cr(`OP_PG2_CALL | 10'h020, 10'h000, 0, 14'h0120, `OP_RT, 0);
		cr(`OP_FAR_CALL | 10'h010, 10'h285, 1, 14'h1805, `OP_RTS, 1);
		cr(`OP_IND_CALL, 10'h2A1, 1, {7'h21, 7'h35}, `OP_RT, 0);
		slow <= 1'b0;
		sk(`OP_CMPM, 10'h000, 0, 1);
		mem_nibble <= 4'h6;
		sk(`OP_CMPM, 10'h000, 0, 0);
		for (int n = 0; n < 16; n += 5) begin
			sk(`OP_SEA, 10'h070 | 10'(n), 1, n == 5);
		end
		jmp(`OP_FAR_JMP | 10'h005, {3'b110, 7'h00}, {7'h45, 7'h00});
		one(`OP_EI);
		rd(32'(`REG_STATUS));
		ck(32'(d[17]), 32'd1);
		one(`OP_DI);
		ck(32'(d[17]), 32'd0);
		one(`OP_EI);
		put(14'h0002, nj(14'h0002));
		irq_req <= 1'b1;
		go();
		irq_req <= 1'b0;
		pc_is(14'h0002);
		ck(32'(d[17:14]), 32'h1);
		wr(32'(`REG_CORE), 32'h0000_0356);
		put(14'h0002, `OP_RTI);
		go();
		pc_is({7'h45, 7'h03});
		rd(32'(`REG_CORE));
		ck(d, core0);
		ext0_event <= 1'b1;
		@(posedge aclk);
		ext0_event <= 1'b0;
		sk(`OP_TEST_EXT0_REQUEST_OP, 10'h000, 0, 1);
		ck(32'(d[19]), 32'd0);
		sk(`OP_TEST_EXT0_REQUEST_OP, 10'h000, 0, 0);
		seta(4'h1);
		one(10'h03F);
		ext0_event <= 1'b1;
		@(posedge aclk);
		ext0_event <= 1'b0;
		sk(`OP_TEST_EXT0_REQUEST_OP, 10'h000, 0, 0);
		ck(32'(d[19]), 32'd1);
		for (int p = 0; p < 4; p++) begin
			seta({1'b0, p[1], 2'b00});
			one(10'h217);
			ext_int_pin <= p[0];
			sk(`OP_TEST_EXT_PIN_LEVEL_OP, 10'h000, 0, p[0] == p[1]);
		end
		seta(4'hE);
		one(`OP_TPAA);
		ck(32'(d[20]), 32'd0);
		seta(4'h9);
		one(`OP_TPAA);
		ck(32'(d[20]), 32'd1);
		one(10'h210);
		rd(32'(`REG_CTL));
		ck(32'(d[23:20]), 32'h9);
		seta(4'h0);
		one(10'h24D);
		rd(32'(`REG_CORE));
		ck(32'(d[3:0]), 32'h9);
		close_out();
	end
endmodule
